// [mfpc_pkg.sv]
package mfpc_pkg;
  // Register indices (byte address is four times the index).
  localparam logic [3:0] MFPC_IDX_GAIN    = 4'h6;
  localparam logic [3:0] MFPC_IDX_RXFILT  = 4'h4;
  localparam logic [3:0] MFPC_IDX_CLKSRC  = 4'h3;
  localparam logic [3:0] MFPC_IDX_TXSET   = 4'h7;
  localparam logic [3:0] MFPC_IDX_RXSET   = 4'h8;
  localparam logic [3:0] MFPC_IDX_GAINSRC = 4'h0;
  localparam logic [3:0] MFPC_IDX_DIEREV  = 4'hF;
  // Field positions.
  localparam int MFPC_B_GAINREG   = 5;
  localparam int MFPC_B_WIDEBAND  = 2;
  localparam int MFPC_B_NEGEDGE   = 7;
  localparam int MFPC_B_DMXBYP    = 0;
  localparam int MFPC_B_WIDTH5    = 1;
  localparam int MFPC_B_LSNFIRST  = 2;
  localparam int MFPC_B_QUIETEN   = 3;
  localparam int MFPC_B_CLKADIS   = 4;
  localparam int MFPC_B_CLKBDIS   = 5;
  localparam int MFPC_B_CLKAINV   = 6;
  localparam int MFPC_B_CLKBINV   = 7;
  localparam int MFPC_B_TRISTATE  = 3;
  // Reset value and highest gain code.
  localparam logic [7:0] MFPC_RST_REG = 8'h00;
  localparam logic [4:0] MFPC_GAIN_MAX = 5'h15;
  // Interpolation select codes.
  localparam logic [3:0] MFPC_INT_4X_LP  = 4'h0;
  localparam logic [3:0] MFPC_INT_2X_LP  = 4'h1;
  localparam logic [3:0] MFPC_INT_BYP    = 4'h2;
  localparam logic [3:0] MFPC_INT_4X_ADJ = 4'h4;
  localparam logic [3:0] MFPC_INT_2X_ADJ = 4'h5;
  localparam logic [3:0] MFPC_INT_4X_LO  = 4'h8;
  localparam logic [3:0] MFPC_INT_4X_HI  = 4'hC;
  // Converter rate divider: one converter tick every this many clk_i cycles.
  localparam logic [3:0] MFPC_DAC_DIV = 4'h2;
  localparam logic [7:0] MFPC_ADC_DIV = 8'h08;
  // Gains in dB, signed, offset so code 0 gives -6 dB.
  localparam int MFPC_GAIN_BASE_DB = -6;
  localparam int MFPC_GAIN_STEP_DB = 2;
  localparam int MFPC_GAIN_WB_CAP_DB = 30;
endpackage

// [mfpc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Nibble buses between the front end and the modem controller.
interface mfpc_link_if;
  logic       tx_clk;          // Device transmit output clock.
  logic [5:0] tx_word;         // Transmit word pins, host driven.
  logic       tx_frame;        // Transmit frame mark, host driven.
  logic       tx_silence_n;    // Transmit silence input, low active.
  logic       gain_strobe;     // Gain strobe pin.
  logic       rx_clk;          // Device receive output clock.
  logic [5:0] rx_word_o;       // Receive word pins, device output value.
  logic       rx_word_oe;      // Receive pins driven when high.
  logic       rx_frame;        // Receive frame mark.
  modport dev  (output tx_clk, input tx_word, input tx_frame, input tx_silence_n,
                input gain_strobe, output rx_clk, output rx_word_o, output rx_word_oe,
                output rx_frame);
  modport host (input tx_clk, output tx_word, output tx_frame, output tx_silence_n,
                output gain_strobe, input rx_clk, input rx_word_o, input rx_word_oe,
                input rx_frame);
endinterface
`default_nettype wire

// [mfpc_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module mfpc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,  // System clock.
  input  wire logic         rst_i,  // Synchronous reset.
  input  wire logic [W-1:0] d_i,    // Asynchronous input.
  output logic      [W-1:0] q_o     // Synchronised output.
);
  logic [W-1:0] s1_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      q_o  <= '0;
    end else begin
      s1_r <= d_i;
      q_o  <= s1_r;
    end
  end
endmodule
`default_nettype wire

// [mfpc_device.sv]
// Summary of operation
// - Gain from register or transmit pins by strobe
// - Codes map -6 to 36 dB, stage split
// - Top four codes capped 30 dB wideband
// - Demux bypass: six-bit samples, frame ignored
// - Width bit selects five/five nibbles, top aligned
// - Order bit sends low nibble first
// - Quiet enable lets silence pin mute output
// - Host flushes interpolator with zeros in demux bypass only
// - Four-bit field selects interpolation mode
// - Transmit clock rate from factor and mode
// - Receive bypass outputs six MSBs only
// - Receive width bit gives five/five nibbles
// - Receive order bit sends low nibble first
// - Three-state bit releases receive pins
// - Clock disable holds output clock low
// - Transmit clock invert bit
// - Receive clock invert moves data edge
// - Read-only die revision register
// - Gain register reads gain in force
// - Falling-edge transmit sampling option
`timescale 1ns/1ps
`default_nettype none
module mfpc_device
  import mfpc_pkg::*;
#(
  parameter logic [7:0] DIE_REV = 8'h01  // Arbitrary revision value.
) (
  input  wire logic        clk_i,       // System clock, 100 MHz.
  input  wire logic        rst_i,       // Synchronous reset, active high.
  mfpc_link_if.dev         link,        // Nibble buses.
  input  wire logic [31:0] wb_adr_i,    // Wishbone address.
  input  wire logic [31:0] wb_dat_i,    // Wishbone write data.
  input  wire logic [3:0]  wb_sel_i,    // Wishbone byte select.
  input  wire logic        wb_we_i,     // Wishbone write enable.
  input  wire logic        wb_cyc_i,    // Wishbone cycle.
  input  wire logic        wb_stb_i,    // Wishbone strobe.
  output logic      [31:0] wb_dat_o,    // Wishbone read data.
  output logic             wb_ack_o,    // Wishbone acknowledge.
  input  wire logic [9:0]  adc_word_i,  // Converter sample to send.
  output logic      [9:0]  dac_word_o,  // Assembled transmit word.
  output logic             dac_vld_o,   // Transmit word strobe.
  output logic             dac_mute_o,  // Output silenced, interpolator down.
  output logic      [3:0]  interp_o,    // Interpolation mode in force.
  output logic      [5:0]  gain_db_o,   // Total gain plus six, in dB.
  output logic      [4:0]  coarse_gain_stage_o, // Coarse gain plus six, dB.
  output logic      [3:0]  fine_gain_stage_o    // Fine gain, dB.
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] gain_ctl_r, rx_filter_r, clk_src_r, tx_set_r, rx_set_r;
  logic [4:0] gain_code_r;
  logic       wb_hit;
  logic [3:0] idx;
  assign idx    = wb_adr_i[5:2];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_ctl_r  <= MFPC_RST_REG;
      rx_filter_r <= MFPC_RST_REG;
      clk_src_r   <= MFPC_RST_REG;
      tx_set_r    <= MFPC_RST_REG;
      rx_set_r    <= MFPC_RST_REG;
    end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      unique case (idx)
        MFPC_IDX_GAINSRC: gain_ctl_r  <= wb_dat_i[7:0];
        MFPC_IDX_RXFILT:  rx_filter_r <= wb_dat_i[7:0];
        MFPC_IDX_CLKSRC:  clk_src_r   <= wb_dat_i[7:0];
        MFPC_IDX_TXSET:   tx_set_r    <= wb_dat_i[7:0];
        MFPC_IDX_RXSET:   rx_set_r    <= wb_dat_i[7:0];
        default: ;  // Die revision and unmapped indices ignore writes.
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_hit) begin
      wb_dat_o <= '0;
      unique case (idx)
        MFPC_IDX_GAINSRC: wb_dat_o[7:0] <= gain_ctl_r;
        MFPC_IDX_RXFILT:  wb_dat_o[7:0] <= rx_filter_r;
        MFPC_IDX_CLKSRC:  wb_dat_o[7:0] <= clk_src_r;
        MFPC_IDX_GAIN:    wb_dat_o[4:0] <= gain_code_r;
        MFPC_IDX_TXSET:   wb_dat_o[7:0] <= tx_set_r;
        MFPC_IDX_RXSET:   wb_dat_o[7:0] <= rx_set_r;
        MFPC_IDX_DIEREV:  wb_dat_o[7:0] <= DIE_REV;
        default:          wb_dat_o      <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flops before use.
  logic [5:0] txw_s;
  logic       txf_s, quiet_n_s, strobe_s, strobe_d_r;
  mfpc_sync2 #(.W(9)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.tx_word, link.tx_frame, link.tx_silence_n, link.gain_strobe}),
    .q_o   ({txw_s, txf_s, quiet_n_s, strobe_s})
  );

  // Pin gain method takes Tx[5:1] on the strobe's rising edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_code_r <= '0;
      strobe_d_r  <= 1'b0;
    end else begin
      strobe_d_r <= strobe_s;
      if (gain_ctl_r[MFPC_B_GAINREG]) begin
        if (wb_hit && wb_we_i && wb_sel_i[0] && idx == MFPC_IDX_GAIN) begin
          gain_code_r <= (wb_dat_i[4:0] > MFPC_GAIN_MAX) ? MFPC_GAIN_MAX : wb_dat_i[4:0];
        end
      end else if (strobe_s && !strobe_d_r) begin
        gain_code_r <= (txw_s[5:1] > MFPC_GAIN_MAX) ? MFPC_GAIN_MAX : txw_s[5:1];
      end
    end
  end

  // Gain map: coarse steps every three codes, fine repeats 6/8/10 for codes 6 to 17.
  logic [5:0] g_nxt;
  logic [4:0] c_nxt;
  logic [3:0] f_nxt;
  always_comb begin
    g_nxt = 6'(gain_code_r) << 1;
    if (gain_code_r < 5'h06) begin
      c_nxt = 5'h00;
      f_nxt = 4'(gain_code_r) << 1;
    end else if (gain_code_r < 5'h12) begin
      c_nxt = 5'(6 * ((gain_code_r - 5'h06) / 3 + 1));
      f_nxt = 4'(6 + 2 * ((gain_code_r - 5'h06) % 3));
    end else if (rx_filter_r[MFPC_B_WIDEBAND]) begin
      g_nxt = 6'(MFPC_GAIN_WB_CAP_DB - MFPC_GAIN_BASE_DB);
      c_nxt = 5'h18;
      f_nxt = 4'hC;
    end else begin
      c_nxt = 5'h1E;
      f_nxt = 4'(6 + 2 * (gain_code_r - 5'h12));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_db_o <= '0;
      coarse_gain_stage_o <= '0;
      fine_gain_stage_o <= '0;
    end else begin
      gain_db_o <= g_nxt;
      coarse_gain_stage_o <= c_nxt;
      fine_gain_stage_o <= f_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit clock: half period from interpolation factor and mux mode.
  logic [3:0] fac;
  logic [4:0] txhalf, txcnt_r;
  logic       txph_r, rxph_r;
  logic [7:0] rxcnt_r;
  always_comb begin
    unique case (tx_set_r[7:4])
      MFPC_INT_BYP:                   fac = 4'h1;
      MFPC_INT_2X_LP, MFPC_INT_2X_ADJ: fac = 4'h2;
      default:                        fac = 4'h4;
    endcase
    // Muxed mode runs twice as fast as non-muxed.
    txhalf = tx_set_r[MFPC_B_DMXBYP] ? 5'(fac * MFPC_DAC_DIV)
                                     : 5'(fac * MFPC_DAC_DIV / 2);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txcnt_r <= '0;
      txph_r  <= 1'b0;
    end else if (txcnt_r + 5'h01 >= txhalf) begin
      txcnt_r <= '0;
      txph_r  <= ~txph_r;
    end else begin
      txcnt_r <= txcnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxcnt_r <= '0;
      rxph_r  <= 1'b0;
    end else if (rxcnt_r + 8'h01 >= MFPC_ADC_DIV) begin
      rxcnt_r <= '0;
      rxph_r  <= ~rxph_r;
    end else begin
      rxcnt_r <= rxcnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.tx_clk <= 1'b0;
      link.rx_clk <= 1'b0;
      interp_o    <= MFPC_INT_4X_LP;
    end else begin
      link.tx_clk <= !rx_set_r[MFPC_B_CLKADIS] && (txph_r ^ rx_set_r[MFPC_B_CLKAINV]);
      link.rx_clk <= !rx_set_r[MFPC_B_CLKBDIS] && (rxph_r ^ rx_set_r[MFPC_B_CLKBINV]);
      interp_o    <= tx_set_r[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sampling on the internal phase edge chosen by the edge bit.
  logic tx_samp, txph_d_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txph_d_r <= 1'b0;
    end else begin
      txph_d_r <= txph_r;
    end
  end
  assign tx_samp = (txph_r != txph_d_r) && (txph_r == !clk_src_r[MFPC_B_NEGEDGE]);

  logic [5:0] first_r;
  logic       have_r;
  logic [9:0] hi_lo;
  always_comb begin
    // First/second nibble to high/low by order bit.
    logic [5:0] hi, lo;
    hi = tx_set_r[MFPC_B_LSNFIRST] ? txw_s : first_r;
    lo = tx_set_r[MFPC_B_LSNFIRST] ? first_r : txw_s;
    // Top-aligned nibbles: 6+4 or 5+5.
    hi_lo = tx_set_r[MFPC_B_WIDTH5] ? {hi[5:1], lo[5:1]} : {hi, lo[5:2]};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_r    <= '0;
      have_r     <= 1'b0;
      dac_word_o <= '0;
      dac_vld_o  <= 1'b0;
      dac_mute_o <= 1'b0;
    end else begin
      dac_vld_o  <= 1'b0;
      dac_mute_o <= tx_set_r[MFPC_B_QUIETEN] && !quiet_n_s;
      if (tx_samp) begin
        if (tx_set_r[MFPC_B_DMXBYP]) begin
          dac_word_o <= {txw_s, 4'h0};
          dac_vld_o  <= 1'b1;
          have_r     <= 1'b0;
        end else if (txf_s) begin
          first_r <= txw_s;
          have_r  <= 1'b1;
        end else if (have_r) begin
          dac_word_o <= hi_lo;
          dac_vld_o  <= 1'b1;
          have_r     <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive port: nibbles change on the internal rising phase.
  logic rxph_d_r, rx_second_r;
  logic [5:0] rhi, rlo;
  assign rhi = rx_set_r[MFPC_B_WIDTH5] ? {adc_word_i[9:5], 1'b0} : adc_word_i[9:4];
  assign rlo = rx_set_r[MFPC_B_WIDTH5] ? {adc_word_i[4:0], 1'b0} : {adc_word_i[3:0], 2'b00};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxph_d_r       <= 1'b0;
      rx_second_r    <= 1'b0;
      link.rx_word_o <= '0;
      link.rx_frame  <= 1'b0;
      link.rx_word_oe <= 1'b0;
    end else begin
      rxph_d_r        <= rxph_r;
      link.rx_word_oe <= !rx_set_r[MFPC_B_TRISTATE];
      if (rxph_r && !rxph_d_r) begin
        if (rx_set_r[MFPC_B_DMXBYP]) begin
          link.rx_word_o <= adc_word_i[9:4];
          link.rx_frame  <= 1'b1;
        end else begin
          rx_second_r    <= !rx_second_r;
          link.rx_frame  <= !rx_second_r;
          link.rx_word_o <= (rx_second_r ^ rx_set_r[MFPC_B_LSNFIRST]) ? rlo : rhi;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [mfpc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module mfpc_host
  import mfpc_pkg::*;
(
  input  wire logic        clk_i,        // System clock, 100 MHz.
  input  wire logic        rst_i,        // Synchronous reset, active high.
  mfpc_link_if.host        link,         // Nibble buses.
  input  wire logic [9:0]  tx_data_i,    // Word to transmit.
  input  wire logic        tx_valid_i,   // Word offered.
  output logic             tx_ready_o,   // Word accepted this cycle.
  input  wire logic        width5_i,     // Matches device width bit.
  input  wire logic        lsn_first_i,  // Matches device order bit.
  input  wire logic        rx_inv_i,     // Matches receive clock invert.
  input  wire logic        silence_i,    // Request transmit silence.
  input  wire logic        gain_load_i,  // Load a gain code through the pins.
  input  wire logic [4:0]  gain_code_i,  // Gain code for the pins.
  output logic      [9:0]  rx_data_o,    // Received word.
  output logic             rx_valid_o    // Received word strobe.
);
  logic [5:0] rw_s;
  logic       rf_s, rc_s, tc_s, tc_d_r, rc_d_r, half_r;
  logic [5:0] rx_first_r, hi, lo;
  logic [9:0] word_r;
  mfpc_sync2 #(.W(9)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    // A released receive bus has no pull, so its pins are taken as the inverse of the device output value, which keeps updating.
    .d_i   ({link.rx_word_o ^ {6{!link.rx_word_oe}}, link.rx_frame, link.rx_clk, link.tx_clk}),
    .q_o   ({rw_s, rf_s, rc_s, tc_s})
  );
  ////////////////////////////////////////////////////////////////////////////
  // Drive on falling tx clock so the device samples a stable nibble on rising.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tc_d_r <= 1'b0;
      half_r <= 1'b0;
      word_r <= '0;
      tx_ready_o <= 1'b0;
      link.tx_word <= '0;
      link.tx_frame <= 1'b0;
      link.tx_silence_n <= 1'b1;
      link.gain_strobe <= 1'b0;
    end else begin
      tc_d_r <= tc_s;
      tx_ready_o <= 1'b0;
      link.tx_silence_n <= !silence_i;
      if (!tc_s && tc_d_r) begin
        link.gain_strobe <= 1'b0;
        if (gain_load_i && !half_r) begin
          link.gain_strobe <= 1'b1;
          link.tx_frame    <= 1'b0;
          link.tx_word     <= {gain_code_i, 1'b0};
        end else if (!half_r) begin
          if (tx_valid_i) begin
            word_r <= tx_data_i;
            tx_ready_o <= 1'b1;
            half_r <= 1'b1;
            link.tx_frame <= 1'b1;
            link.tx_word <= lsn_first_i ?
              (width5_i ? {tx_data_i[4:0], 1'b0} : {tx_data_i[3:0], 2'b00}) :
              (width5_i ? {tx_data_i[9:5], 1'b0} : tx_data_i[9:4]);
          end else begin
            link.tx_frame <= 1'b0;
            link.tx_word <= '0;  // Idle zeros, unframed, flush the interpolator in demux bypass only.
          end
        end else begin
          half_r <= 1'b0;
          link.tx_frame <= 1'b0;
          link.tx_word <= !lsn_first_i ?
            (width5_i ? {word_r[4:0], 1'b0} : {word_r[3:0], 2'b00}) :
            (width5_i ? {word_r[9:5], 1'b0} : word_r[9:4]);
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sample receive nibbles on the edge opposite to the device launch edge.
  assign hi = lsn_first_i ? rw_s : rx_first_r;
  assign lo = lsn_first_i ? rx_first_r : rw_s;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_d_r <= 1'b0;
      rx_first_r <= '0;
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
    end else begin
      rc_d_r <= rc_s;
      rx_valid_o <= 1'b0;
      if ((rc_s != rc_d_r) && (rc_s == rx_inv_i)) begin
        if (rf_s) begin
          rx_first_r <= rw_s;
        end else begin
          rx_valid_o <= 1'b1;
          rx_data_o <= width5_i ? {hi[5:1], lo[5:1]} : {hi, lo[5:2]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [mfpc_props.sv]
`timescale 1ns/1ps
`default_nettype none
module mfpc_props (
  input wire logic       clk_i,         // System clock.
  input wire logic       rst_i,         // Synchronous reset, active high.
  input wire logic       tx_clk,        // Transmit output clock.
  input wire logic [5:0] tx_word,       // Transmit word pins.
  input wire logic       tx_frame,      // Transmit frame mark.
  input wire logic       tx_silence_n,  // Transmit silence, low active.
  input wire logic       gain_strobe,   // Gain strobe pin.
  input wire logic       rx_clk,        // Receive output clock.
  input wire logic [5:0] rx_word_o,     // Receive word pins.
  input wire logic       rx_word_oe,    // Receive pins driven when high.
  input wire logic       rx_frame       // Receive frame mark.
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // The shortest transmit period is two cycles, so a frame seen at one rise must be
  // gone at the next rise or two nibbles could never pair into one word.
  sequence s_frame_rise;
    tx_frame && $rose(tx_clk);
  endsequence
  sequence s_no_frame_rise;
    (!tx_frame || !$rose(tx_clk)) [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_dev_reset: assert property ($fell(rst_i) |-> !tx_clk && !rx_clk && !rx_frame && !rx_word_oe)
    else $error("device link outputs not idle after reset");
  a_host_reset: assert property ($fell(rst_i) |-> tx_silence_n && !tx_frame && tx_word == 6'h00)
    else $error("host link outputs not idle after reset");
  a_strobe_no_frame: assert property (gain_strobe |-> !tx_frame)
    else $error("gain strobe raised during a transmit frame");
  a_tx_clk_high: assert property (tx_clk [*8] |=> !tx_clk)
    else $error("transmit clock high longer than its longest half period");
  a_rx_clk_high: assert property (rx_clk [*8] |=> !rx_clk)
    else $error("receive clock high longer than its half period");
  a_frame_pairs: assert property (s_frame_rise |=> s_no_frame_rise)
    else $error("frame mark held over two transmit nibbles");
  a_tx_launch: assert property (($changed(tx_word) || $changed(tx_frame)) |-> !tx_clk)
    else $error("transmit data changed while the transmit clock was high");
  a_silence_hold: assert property ($changed(tx_silence_n) |=> $stable(tx_silence_n) [*2])
    else $error("silence pin glitched");
endmodule
`default_nettype wire

// [mfpc_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module mfpc_tb;
  import mfpc_pkg::*;
  localparam logic [7:0] REV = 8'h5A;  // Arbitrary revision value.
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, interp_o, fine_gain_stage_o;
  logic [9:0]  adc_word_i, dac_word_o, tx_data_i, rx_data_o;
  logic        dac_vld_o, dac_mute_o, tx_valid_i, tx_ready_o, rx_valid_o;
  logic        width5_i, lsn_first_i, rx_inv_i, silence_i, gain_load_i;
  logic [5:0]  gain_db_o;
  logic [4:0]  coarse_gain_stage_o, gain_code_i;
  int          err_total, num_checks;
  logic [3:0]  icode [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h8, 4'hC};
  int          ifac  [7] = '{4, 2, 1, 4, 2, 4, 4};

  mfpc_link_if link ();
  mfpc_device #(.DIE_REV(REV)) u_mfpc_device (.clk_i(clk_i), .rst_i(rst_i), .link(link.dev),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .adc_word_i(adc_word_i), .dac_word_o(dac_word_o), .dac_vld_o(dac_vld_o),
    .dac_mute_o(dac_mute_o), .interp_o(interp_o), .gain_db_o(gain_db_o),
    .coarse_gain_stage_o(coarse_gain_stage_o), .fine_gain_stage_o(fine_gain_stage_o));
  mfpc_host u_mfpc_host (.clk_i(clk_i), .rst_i(rst_i), .link(link.host),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .width5_i(width5_i), .lsn_first_i(lsn_first_i), .rx_inv_i(rx_inv_i),
    .silence_i(silence_i), .gain_load_i(gain_load_i), .gain_code_i(gain_code_i),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o));
  mfpc_props u_mfpc_props (.clk_i(clk_i), .rst_i(rst_i), .tx_clk(link.tx_clk),
    .tx_word(link.tx_word), .tx_frame(link.tx_frame), .tx_silence_n(link.tx_silence_n),
    .gain_strobe(link.gain_strobe), .rx_clk(link.rx_clk), .rx_word_o(link.rx_word_o),
    .rx_word_oe(link.rx_word_oe), .rx_frame(link.rx_frame));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = dac_vld_o;
      1: pick = rx_valid_o;
      2: pick = tx_ready_o;
      3: pick = link.tx_clk;
      default: pick = (dac_vld_o === 1'b1 && dac_word_o === 10'h3A0);
    endcase
  endfunction
  // Outputs are sampled on the falling edge, where every registered value has settled.
  task automatic wait_lvl(input int k, input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (pick(k) !== lvl && n < 400);
    if (n >= 400) begin
      err_total++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      end_of_test;
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    wb_adr_i <= {26'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, wd};
    wb_we_i  <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED at %0t: bus answer ran out", $time);
      end_of_test;
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] x;
    wb(1'b1, idx, d, x);
  endtask
  task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    wb(1'b0, idx, 8'h00, d);
    check(d, exp);
  endtask
  task automatic send(input logic [9:0] w);
    int n;
    @(posedge clk_i);
    tx_data_i  <= w;
    tx_valid_i <= 1'b1;
    wait_lvl(2, 1'b1, n);
    @(posedge clk_i);
    tx_valid_i <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n, p, tot, cg;
    logic [9:0] w;
    {err_total, num_checks} = '0;
    {wb_we_i, wb_cyc_i, wb_stb_i, tx_valid_i, silence_i} = '0;
    {width5_i, lsn_first_i, rx_inv_i, gain_load_i, gain_code_i} = '0;
    {wb_adr_i, wb_dat_i} = '0;
    wb_sel_i   = 4'hF;
    tx_data_i  = 10'h000;
    adc_word_i = 10'h2C9;
    rst_i      = 1'b1;
    tick(5);
    rst_i <= 1'b0;
    rchk(4'h7, 8'h00);
    rchk(4'h8, 8'h00);
    rchk(4'h6, 8'h00);
    rchk(4'hF, REV);
    check(gain_db_o, 6'h00);
    wr(4'hF, 8'hFF);
    rchk(4'hF, REV);
    wr(4'hE, 8'h3C);
    rchk(4'hE, 8'h00);
    $display("Test registers done");
    wr(4'h0, 8'h20);
    for (int wide = 0; wide < 2; wide++) begin
      wr(4'h4, wide[0] ? 8'h04 : 8'h00);
      for (int c = 0; c < 22; c++) begin
        wr(4'h6, 8'(c));
        rchk(4'h6, 8'(c));
        tot = 2 * c - 6;
        cg  = (c < 6) ? -6 : (c < 18) ? 6 * ((c - 6) / 3) : 24;
        if (c >= 18 && wide == 1) begin
          tot = 30;
          cg  = 18;
        end
        check(gain_db_o, tot + 6);
        check(coarse_gain_stage_o, cg + 6);
        check(fine_gain_stage_o, tot - cg);
      end
    end
    wr(4'h6, 8'h1F);
    rchk(4'h6, 8'h15);
    wr(4'h0, 8'h00);
    gain_load_i <= 1'b1;
    gain_code_i <= 5'h0B;
    tick(20);
    gain_load_i <= 1'b0;
    tick(20);
    rchk(4'h6, 8'h0B);
    check(gain_db_o, 6'h16);
    $display("Test gain map done");
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 7; i++) begin
        wr(4'h7, {icode[i], 3'h0, b[0]});
        tick(1);
        check(interp_o, icode[i]);
        wait_lvl(3, 1'b0, n);
        wait_lvl(3, 1'b1, n);
        wait_lvl(3, 1'b0, p);
        wait_lvl(3, 1'b1, n);
        check(p + n, (b + 1) * 2 * ifac[i]);
      end
    end
    $display("Test interpolation done");
    for (int m = 0; m < 4; m++) begin
      wr(4'h7, {5'h00, m[1], m[0], 1'h0});
      width5_i    <= m[0];
      lsn_first_i <= m[1];
      for (int j = 0; j < 2; j++) begin
        w = j[0] ? 10'h05A : 10'h3A5;
        send(w);
        wait_lvl(0, 1'b1, n);
        check(dac_word_o, w);
      end
    end
    width5_i    <= 1'b0;
    lsn_first_i <= 1'b0;
    wr(4'h7, 8'h01);
    send(10'h3A5);
    wait_lvl(4, 1'b1, n);
    check(dac_word_o, 10'h3A0);
    wr(4'h7, 8'h00);
    silence_i <= 1'b1;
    tick(10);
    check(dac_mute_o, 1'b0);
    wr(4'h7, 8'h08);
    tick(10);
    check(dac_mute_o, 1'b1);
    silence_i <= 1'b0;
    tick(10);
    check(dac_mute_o, 1'b0);
    wr(4'h7, 8'h00);
    // Ten cycles after a rising edge the plain clock is high again, so inverted it is low.
    wait_lvl(3, 1'b0, n);
    wait_lvl(3, 1'b1, n);
    wr(4'h8, 8'h40);
    repeat (8) @(negedge clk_i);
    check(link.tx_clk, 1'b0);
    wr(4'h3, 8'h80);
    send(10'h1C3);
    wait_lvl(0, 1'b1, n);
    check(dac_word_o, 10'h1C3);
    wr(4'h3, 8'h00);
    wr(4'h8, 8'h00);
    $display("Test transmit done");
    // The first received word after a change may straddle it, so the second is judged.
    for (int m = 0; m < 5; m++) begin
      wr(4'h8, {m[2], 4'h0, m[1], m[0], 1'h0});
      width5_i    <= m[0];
      lsn_first_i <= m[1];
      rx_inv_i    <= m[2];
      wait_lvl(1, 1'b1, n);
      wait_lvl(1, 1'b1, n);
      check(rx_data_o, 10'h2C9);
    end
    check(link.rx_word_oe, 1'b1);
    wr(4'h8, 8'h01);
    tick(40);
    n = 0;
    repeat (20) begin
      @(negedge clk_i);
      if (link.rx_word_o !== 6'h2C) n++;
    end
    check(n, 0);
    wr(4'h8, 8'h08);
    tick(4);
    check(link.rx_word_oe, 1'b0);
    wr(4'h8, 8'h30);
    tick(2);
    n = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (link.tx_clk !== 1'b0 || link.rx_clk !== 1'b0) n++;
    end
    check(n, 0);
    wr(4'h8, 8'h00);
    $display("Test receive done");
    end_of_test;
  end
endmodule
`default_nettype wire
